// ---- tacs_defs.vh ----
// Constants for the touch converter control sequencer
`ifndef TACS_DEFS_VH
`define TACS_DEFS_VH
`define TACS_CTRL_ADDR 5'h00
`define TACS_B_PEN 15
`define TACS_B_STS 14
`define TACS_FN_HI 13
`define TACS_FN_LO 10
`define TACS_RES_HI 9
`define TACS_RES_LO 8
`define TACS_AVG_HI 7
`define TACS_AVG_LO 6
`define TACS_CLK_HI 5
`define TACS_CLK_LO 4
`define TACS_PV_HI 3
`define TACS_PV_LO 1
`define TACS_FN_NONE 4'h0
`define TACS_FN_XY 4'h1
`define TACS_FN_XYZ 4'h2
`define TACS_FN_X 4'h3
`define TACS_FN_Y 4'h4
`define TACS_FN_Z 4'h5
`define TACS_FN_BATTERY_INPUT_1_RESULT 4'h6
`define TACS_FN_BATTERY_INPUT_2_RESULT 4'h7
`define TACS_FN_AUXILIARY_INPUT_1_RESULT 4'h8
`define TACS_FN_AUXILIARY_INPUT_2_RESULT 4'h9
`define TACS_FN_TEMP1 4'ha
`define TACS_FN_PORT 4'hb
`define TACS_FN_TEMP2 4'hc
`define TACS_FN_DRV_X 4'hd
`define TACS_FN_DRV_Y 4'he
`define TACS_FN_DRV_YX 4'hf
// Result register indices
`define TACS_RI_X 4'h0
`define TACS_RI_Y 4'h1
`define TACS_RI_Z1 4'h2
`define TACS_RI_Z2 4'h3
`define TACS_RI_BATTERY_INPUT_1_RESULT 4'h4
`define TACS_RI_BATTERY_INPUT_2_RESULT 4'h5
`define TACS_RI_AUXILIARY_INPUT_1_RESULT 4'h6
`define TACS_RI_AUXILIARY_INPUT_2_RESULT 4'h7
`define TACS_RI_TEMP1 4'h8
`define TACS_RI_TEMP2 4'h9
// Panel driver enables: {xp, xn, yp, yn}
`define TACS_DRV_OFF 4'h0
`define TACS_DRV_XX 4'hc
`define TACS_DRV_YY 4'h3
`define TACS_DRV_YPXN 4'h6
// Times and clock rate
`define TACS_MCLK_MHZ 100
`define TACS_US_100 100
`define TACS_US_500 500
`define TACS_US_1000 1000
`define TACS_US_5000 5000
`define TACS_US_10000 10000
`define TACS_US_50000 50000
`define TACS_US_100000 100000
`define TACS_SETTLE_W 24
`define TACS_BITS_12 5'd12
`define TACS_BITS_10 5'd10
`define TACS_BITS_8 5'd8
`endif

// ---- tacs_sequencer.v ----
// Converter control register and conversion sequencer
`timescale 1ns/10ps
`include "tacs_defs.vh"

// Operation
// - Reading bit 15 shows whether the panel is touched now.
// - Bit 15 written picks host or touch-started conversions; host after reset.
// - Bit 14 reads 0 while busy, 1 when results are ready.
// - Writing 0 to bit 14 lets scans repeat until pen lift or stop.
// - Writing 1 to bit 14 aborts everything at once and powers converter down.
// - Bit 14 reads 1 after reset.
// - Function field bits 13..10 selects input and mode, reads back as written.
// - Function 0 measures nothing and writes no result; reset default.
// - Function 1 repeats X and Y until pen lift or stop.
// - Function 2 repeats X, Y, Z1, Z2 until pen lift or stop.
// - Function 3 does X, 4 does Y, 5 does Z1 and Z2.
// - Functions 6 to 9 convert battery 1, battery 2, aux 1, aux 2.
// - Function 10 is temperature one; 12 is differential temperature two.
// - Function 11 scans both batteries and both aux inputs in turn.
// - Functions 13 to 15 convert nothing and switch on panel driver pairs.
// - Resolution bits 9..8: 00 and 11 twelve, 01 eight, 10 ten bits.
// - Averaging bits 7..6: none, 4, 8 or 16 conversions; reads back.
// - While averaging, status and data-ready show busy until all done.
// - Clock bits 5..4 select 8, 4, 2 or 1 MHz conversion clock.
// - Settle bits 3..1 delay from touch to conversion start.
// - Bit 0 ignores writes and reads as zero.
// - Each result goes to the result register of the chosen function.
module tacs_sequencer #(
	parameter DATA_W = 12,
	parameter [`TACS_SETTLE_W-1:0] SETTLE_100US = `TACS_US_100 * `TACS_MCLK_MHZ,
	parameter [`TACS_SETTLE_W-1:0] SETTLE_500US = `TACS_US_500 * `TACS_MCLK_MHZ,
	parameter [`TACS_SETTLE_W-1:0] SETTLE_1MS = `TACS_US_1000 * `TACS_MCLK_MHZ,
	parameter [`TACS_SETTLE_W-1:0] SETTLE_5MS = `TACS_US_5000 * `TACS_MCLK_MHZ,
	parameter [`TACS_SETTLE_W-1:0] SETTLE_10MS = `TACS_US_10000 * `TACS_MCLK_MHZ,
	parameter [`TACS_SETTLE_W-1:0] SETTLE_50MS = `TACS_US_50000 * `TACS_MCLK_MHZ,
	parameter [`TACS_SETTLE_W-1:0] SETTLE_100MS = `TACS_US_100000 * `TACS_MCLK_MHZ
) (
	input wire mclk_i,
	input wire rst_b_i,
	input wire ce_i,
	input wire [4:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [15:0] reg_wdata_i,
	output reg [15:0] reg_rdata_o,
	input wire pen_down_i,
	output reg conv_start_o,
	output reg [4:0] conv_bits_o,
	output reg [1:0] conv_clk_sel_o,
	input wire conv_done_i,
	input wire [DATA_W-1:0] conv_data_i,
	output reg conv_pwr_o,
	output reg [3:0] conv_input_o,
	output reg [3:0] drv_en_o,
	output reg res_wr_o,
	output reg [3:0] res_idx_o,
	output reg [DATA_W-1:0] res_data_o,
	output reg data_ready_output_b_o
);

	// ************************************************************
	// Local state
	// ************************************************************
	// Sequence: wait for pen, settle, start, convert, write result
	localparam ST_IDLE = 3'd0;
	localparam ST_WAIT_PEN = 3'd1;
	localparam ST_SETTLE = 3'd2;
	localparam ST_START = 3'd3;
	localparam ST_CONV = 3'd4;
	localparam ST_NEXT = 3'd5;

	reg [2:0] state;
	reg pen_mode_status;
	reg [3:0] function_select;
	reg [1:0] resolution_select;
	reg [1:0] averaging_select;
	reg [1:0] conversion_clock_select;
	reg [2:0] panel_settle_select;
	reg converter_state;
	reg pen_meta;
	reg pen_down_flag;
	reg [1:0] step;
	reg [4:0] avg_cnt;
	reg [DATA_W+3:0] acc;
	reg [`TACS_SETTLE_W-1:0] settle_cnt;

	wire ctrl_wr = reg_wr_i && (reg_addr_i == `TACS_CTRL_ADDR);
	wire stop_wr = ctrl_wr && reg_wdata_i[`TACS_B_STS];
	wire go_wr = ctrl_wr && !reg_wdata_i[`TACS_B_STS];

	// ************************************************************
	// Decodes
	// ************************************************************
	reg [3:0] cur_idx;
	reg [1:0] last_step;
	reg is_conv;
	reg repeats;
	reg touch_fn;
	reg [4:0] avg_n;
	reg [4:0] next_bits;
	reg [`TACS_SETTLE_W-1:0] settle_len;
	reg [3:0] drv_sel;

	always @* begin
		cur_idx = `TACS_RI_X;
		last_step = 2'd0;
		is_conv = 1'b1;
		repeats = 1'b0;
		touch_fn = 1'b0;
		drv_sel = `TACS_DRV_OFF;
		case (function_select)
			`TACS_FN_XY: begin
				cur_idx = step[0] ? `TACS_RI_Y : `TACS_RI_X;
				last_step = 2'd1;
				repeats = 1'b1;
				touch_fn = 1'b1;
			end
			`TACS_FN_XYZ: begin
				cur_idx = {2'b00, step};
				last_step = 2'd3;
				repeats = 1'b1;
				touch_fn = 1'b1;
			end
			`TACS_FN_X: begin
				cur_idx = `TACS_RI_X;
				touch_fn = 1'b1;
			end
			`TACS_FN_Y: begin
				cur_idx = `TACS_RI_Y;
				touch_fn = 1'b1;
			end
			`TACS_FN_Z: begin
				cur_idx = step[0] ? `TACS_RI_Z2 : `TACS_RI_Z1;
				last_step = 2'd1;
				touch_fn = 1'b1;
			end
			`TACS_FN_BATTERY_INPUT_1_RESULT: cur_idx = `TACS_RI_BATTERY_INPUT_1_RESULT;
			`TACS_FN_BATTERY_INPUT_2_RESULT: cur_idx = `TACS_RI_BATTERY_INPUT_2_RESULT;
			`TACS_FN_AUXILIARY_INPUT_1_RESULT: cur_idx = `TACS_RI_AUXILIARY_INPUT_1_RESULT;
			`TACS_FN_AUXILIARY_INPUT_2_RESULT: cur_idx = `TACS_RI_AUXILIARY_INPUT_2_RESULT;
			`TACS_FN_TEMP1: cur_idx = `TACS_RI_TEMP1;
			`TACS_FN_TEMP2: cur_idx = `TACS_RI_TEMP2;
			`TACS_FN_PORT: begin
				cur_idx = `TACS_RI_BATTERY_INPUT_1_RESULT + {2'b00, step};
				last_step = 2'd3;
			end
			`TACS_FN_DRV_X: begin
				is_conv = 1'b0;
				drv_sel = `TACS_DRV_XX;
			end
			`TACS_FN_DRV_Y: begin
				is_conv = 1'b0;
				drv_sel = `TACS_DRV_YY;
			end
			`TACS_FN_DRV_YX: begin
				is_conv = 1'b0;
				drv_sel = `TACS_DRV_YPXN;
			end
			default: is_conv = 1'b0;
		endcase
		case (averaging_select)
			2'd1: avg_n = 5'd4;
			2'd2: avg_n = 5'd8;
			2'd3: avg_n = 5'd16;
			default: avg_n = 5'd1;
		endcase
		case (resolution_select)
			2'd1: next_bits = `TACS_BITS_8;
			2'd2: next_bits = `TACS_BITS_10;
			default: next_bits = `TACS_BITS_12;
		endcase
		case (panel_settle_select)
			3'd1: settle_len = SETTLE_100US;
			3'd2: settle_len = SETTLE_500US;
			3'd3: settle_len = SETTLE_1MS;
			3'd4: settle_len = SETTLE_5MS;
			3'd5: settle_len = SETTLE_10MS;
			3'd6: settle_len = SETTLE_50MS;
			3'd7: settle_len = SETTLE_100MS;
			default: settle_len = {`TACS_SETTLE_W{1'b0}};
		endcase
	end

	// Average of the accumulated samples
	reg [DATA_W+3:0] avg_val;
	always @* begin
		case (averaging_select)
			2'd1: avg_val = acc >> 2;
			2'd2: avg_val = acc >> 3;
			2'd3: avg_val = acc >> 4;
			default: avg_val = acc;
		endcase
	end

	wire [DATA_W+3:0] acc_sum = acc + {4'h0, conv_data_i};

	// ************************************************************
	// Pen synchroniser
	// ************************************************************
	// The pen pin is asynchronous: two flops before any logic reads it
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			pen_meta <= 1'b0;
			pen_down_flag <= 1'b0;
		end else if (ce_i) begin
			pen_meta <= pen_down_i;
			pen_down_flag <= pen_meta;
		end
	end

	// ************************************************************
	// Control register and sequencer
	// ************************************************************
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
			pen_mode_status <= 1'b0;
			function_select <= `TACS_FN_NONE;
			resolution_select <= 2'b00;
			averaging_select <= 2'b00;
			conversion_clock_select <= 2'b00;
			panel_settle_select <= 3'b000;
			converter_state <= 1'b1;
			step <= 2'd0;
			avg_cnt <= 5'd0;
			acc <= {(DATA_W+4){1'b0}};
			settle_cnt <= {`TACS_SETTLE_W{1'b0}};
			reg_rdata_o <= 16'h0000;
			conv_start_o <= 1'b0;
			conv_bits_o <= `TACS_BITS_12;
			conv_clk_sel_o <= 2'b00;
			conv_pwr_o <= 1'b0;
			conv_input_o <= 4'h0;
			drv_en_o <= `TACS_DRV_OFF;
			res_wr_o <= 1'b0;
			res_idx_o <= 4'h0;
			res_data_o <= {DATA_W{1'b0}};
			data_ready_output_b_o <= 1'b1;
		end else if (ce_i) begin
			conv_start_o <= 1'b0;
			res_wr_o <= 1'b0;
			conv_bits_o <= next_bits;
			conv_clk_sel_o <= conversion_clock_select;
			conv_input_o <= function_select;
			drv_en_o <= (state == ST_IDLE) ? drv_sel : `TACS_DRV_OFF;
			// Bit 0 always reads zero
			reg_rdata_o <= {pen_down_flag, converter_state, function_select,
				resolution_select, averaging_select, conversion_clock_select,
				panel_settle_select, 1'b0};
			// Active low: low while no conversion is pending
			data_ready_output_b_o <= !converter_state;
			if (ctrl_wr) begin
				pen_mode_status <= reg_wdata_i[`TACS_B_PEN];
				function_select <= reg_wdata_i[`TACS_FN_HI:`TACS_FN_LO];
				resolution_select <= reg_wdata_i[`TACS_RES_HI:`TACS_RES_LO];
				averaging_select <= reg_wdata_i[`TACS_AVG_HI:`TACS_AVG_LO];
				conversion_clock_select <= reg_wdata_i[`TACS_CLK_HI:`TACS_CLK_LO];
				panel_settle_select <= reg_wdata_i[`TACS_PV_HI:`TACS_PV_LO];
			end
			// A stop write wins over everything else
			if (stop_wr) begin
				state <= ST_IDLE;
				conv_pwr_o <= 1'b0;
				converter_state <= 1'b1;
			end else if (go_wr) begin
				state <= ST_IDLE;
				step <= 2'd0;
				// Functions that convert nothing leave the converter idle
				converter_state <= 1'b1;
				if (reg_wdata_i[`TACS_FN_HI:`TACS_FN_LO] != `TACS_FN_NONE &&
					reg_wdata_i[`TACS_FN_HI:`TACS_FN_LO] < `TACS_FN_DRV_X) begin
					state <= ST_WAIT_PEN;
					converter_state <= 1'b0;
				end
			end else begin
				case (state)
					ST_IDLE: conv_pwr_o <= 1'b0;
					ST_WAIT_PEN: begin
						// Touch-started mode waits for the pen on touch functions 1 to 5 only
						if (!is_conv) begin
							state <= ST_IDLE;
							converter_state <= 1'b1;
						end else if (!(pen_mode_status && touch_fn) || pen_down_flag) begin
							settle_cnt <= (pen_mode_status && touch_fn) ?
								settle_len : {`TACS_SETTLE_W{1'b0}};
							state <= ST_SETTLE;
						end
					end
					ST_SETTLE: begin
						if (pen_mode_status && touch_fn && !pen_down_flag) begin
							// Pen lifted while settling: abandon the scan
							state <= ST_IDLE;
							converter_state <= 1'b1;
						end else if (settle_cnt == {`TACS_SETTLE_W{1'b0}}) begin
							state <= ST_START;
							avg_cnt <= 5'd0;
							acc <= {(DATA_W+4){1'b0}};
						end else begin
							settle_cnt <= settle_cnt - 1'b1;
						end
					end
					ST_START: begin
						conv_pwr_o <= 1'b1;
						conv_start_o <= 1'b1;
						state <= ST_CONV;
					end
					ST_CONV: begin
						// Sum samples until the averaging count is reached
						if (conv_done_i) begin
							acc <= acc_sum;
							avg_cnt <= avg_cnt + 1'b1;
							if (avg_cnt + 1'b1 == avg_n) begin
								state <= ST_NEXT;
							end else begin
								state <= ST_START;
							end
						end
					end
					ST_NEXT: begin
						// Write the averaged result, then next step, next scan or idle
						res_wr_o <= 1'b1;
						res_idx_o <= cur_idx;
						res_data_o <= avg_val[DATA_W-1:0];
						avg_cnt <= 5'd0;
						acc <= {(DATA_W+4){1'b0}};
						if (step != last_step) begin
							step <= step + 1'b1;
							state <= ST_START;
						end else if (repeats && (pen_down_flag || !pen_mode_status)) begin
							step <= 2'd0;
							state <= ST_WAIT_PEN;
						end else begin
							step <= 2'd0;
							state <= ST_IDLE;
							converter_state <= 1'b1;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

// ---- tacs_seq_chk.sv ----
// Timing checks on the ports of the converter control sequencer
`timescale 1ns/10ps
module tacs_seq_chk (
	input wire mclk_i,
	input wire rst_b_i,
	input wire ce_i,
	input wire [4:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [15:0] reg_wdata_i,
	input wire [15:0] reg_rdata_o,
	input wire pen_down_i,
	input wire conv_start_o,
	input wire conv_pwr_o,
	input wire [3:0] conv_input_o,
	input wire [3:0] drv_en_o,
	input wire res_wr_o,
	input wire [3:0] res_idx_o,
	input wire data_ready_output_b_o
);
	// ****
	// Checks
	// ****
	wire wr0 = ce_i && reg_wr_i && reg_addr_i == 5'h00;
	wire [3:0] fn = reg_wdata_i[13:10];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	chk_bit0_zero: assert property (reg_rdata_o[0] == 1'b0)
		else $error("bit 0 reads one");
	chk_fields_back: assert property (wr0 |-> ##2 reg_rdata_o[13:1] == $past(reg_wdata_i[13:1], 2))
		else $error("fields differ from write");
	chk_stop_abort: assert property (wr0 && reg_wdata_i[14] |=> !conv_pwr_o ##1 reg_rdata_o[14])
		else $error("stop did not power down");
	chk_host_start: assert property (wr0 && reg_wdata_i[15:14] == 2'b00 && fn != 4'h0 && fn < 4'hd
		&& reg_wdata_i[3:1] == 3'h0 |-> ##4 conv_start_o)
		else $error("no start after host write");
	chk_busy_start: assert property (conv_start_o |-> data_ready_output_b_o && !reg_rdata_o[14])
		else $error("ready shown while converting");
	chk_none_idle: assert property (conv_input_o == 4'h0 |-> !conv_start_o && !res_wr_o)
		else $error("function zero converts");
	chk_drv_xx: assert property ((conv_input_o == 4'hd)[*3] |-> drv_en_o == 4'hc)
		else $error("x drivers not on");
	chk_single_index: assert property (res_wr_o && conv_input_o >= 4'h6 && conv_input_o <= 4'ha
		|-> res_idx_o == conv_input_o - 4'h2)
		else $error("wrong result index");
	chk_pen_high: assert property (pen_down_i[*6] |-> reg_rdata_o[15])
		else $error("pen flag low while touched");
	chk_pen_low: assert property ((!pen_down_i)[*6] |-> !reg_rdata_o[15])
		else $error("pen flag high while released");
endmodule

// ---- tacs_adc_model.sv ----
// Converter model answering start pulses with numbered samples
`timescale 1ns/10ps
module tacs_adc_model #(
	parameter DATA_W = 12
) (
	input wire mclk_i,
	input wire conv_start_i,
	output reg conv_done_o,
	output reg [DATA_W-1:0] conv_data_o,
	output reg [15:0] smp_cnt_o
);
	// ****
	// Model
	// ****
	reg [3:0] wait_cnt;
	reg busy;
	initial begin
		conv_done_o = 1'b0;
		conv_data_o = 0;
		smp_cnt_o = 16'h0000;
		busy = 1'b0;
		wait_cnt = 4'h0;
	end
	// Odd samples take longer; data line toggles outside the done pulse
	always @(posedge mclk_i) begin
		conv_done_o <= 1'b0;
		conv_data_o <= ~conv_data_o;
		if (conv_start_i) begin
			busy <= 1'b1;
			wait_cnt <= smp_cnt_o[0] ? 4'h9 : 4'h1;
		end else if (busy && wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			conv_done_o <= 1'b1;
			conv_data_o <= smp_cnt_o[DATA_W-1:0];
			smp_cnt_o <= smp_cnt_o + 16'h0001;
		end
	end
endmodule

// ---- tb.sv ----
// Self-checking bench for the converter control sequencer
`timescale 1ns/10ps
module tb;
	// ****
	// Bench
	// ****
	reg mclk_i, rst_b_i, pen_down_i, reg_wr_i, ce_i;
	reg [4:0] reg_addr_i;
	reg [15:0] reg_wdata_i;
	wire [15:0] reg_rdata_o, smp_cnt;
	wire conv_start_o, conv_done_i, conv_pwr_o, res_wr_o, data_ready_output_b_o;
	wire [4:0] conv_bits_o;
	wire [1:0] conv_clk_sel_o;
	wire [11:0] conv_data_i, res_data_o;
	wire [3:0] conv_input_o, drv_en_o, res_idx_o;
	integer mismatches = 0, comparisons = 0, k, i, c;
	tacs_sequencer #(.SETTLE_100US(24'd10), .SETTLE_500US(24'd20)) i_tacs_sequencer (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.pen_down_i(pen_down_i), .conv_start_o(conv_start_o), .conv_bits_o(conv_bits_o),
		.conv_clk_sel_o(conv_clk_sel_o), .conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i), .conv_pwr_o(conv_pwr_o), .conv_input_o(conv_input_o),
		.drv_en_o(drv_en_o), .res_wr_o(res_wr_o), .res_idx_o(res_idx_o),
		.res_data_o(res_data_o), .data_ready_output_b_o(data_ready_output_b_o));
	tacs_adc_model i_tacs_adc_model (.mclk_i(mclk_i),
		.conv_start_i(conv_start_o), .conv_done_o(conv_done_i),
		.conv_data_o(conv_data_i), .smp_cnt_o(smp_cnt));
	task print_verdict;
		begin
			if (mismatches == 0 && comparisons > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [4:0] a, input [15:0] d);
		begin
			@(negedge mclk_i);
			reg_addr_i = a;
			reg_wdata_i = d;
			reg_wr_i = 1'b1;
			@(negedge mclk_i);
			reg_wr_i = 1'b0;
		end
	endtask
	// Bounded wait on start, result write or ready status
	task wt(input integer s);
		begin
			k = 0;
			while (!(s == 0 ? conv_start_o : s == 1 ? res_wr_o : reg_rdata_o[14] === 1'b1)
				&& k < 900) begin
				@(negedge mclk_i);
				k = k + 1;
			end
		end
	endtask
	task scan(input [15:0] w, input [15:0] ix, input integer n);
		integer j, nav;
		begin
			repeat (20) @(negedge mclk_i);
			nav = w[7:6] == 2'b00 ? 1 : 2 << w[7:6];
			c = smp_cnt;
			wr(5'h00, w);
			if (w[15]) begin
				k = 0;
				repeat (40) begin
					@(negedge mclk_i);
					k = k + conv_start_o;
				end
				chk("early", k, 0);
				pen_down_i = 1'b1;
				wt(0);
				chk("settle", k >= w[3:1] * 10 && k <= w[3:1] * 10 + 10, 1);
			end
			for (j = 0; j < n; j = j + 1) begin
				wt(1);
				chk("index", res_idx_o, ix[15 - 4 * j -: 4]);
				chk("data", res_data_o, c + (nav - 1) / 2);
				c = c + nav;
				@(negedge mclk_i);
			end
			chk("bits", conv_bits_o, w[9:8] == 2'b01 ? 8 : w[9:8] == 2'b10 ? 10 : 12);
			chk("clock", conv_clk_sel_o, w[5:4]);
			if (w[13:10] == 4'h1 || w[13:10] == 4'h2) begin
				if (w[15])
					pen_down_i = 1'b0;
				else
					wr(5'h00, w | 16'h4000);
			end
			k = 0;
			repeat (30) begin
				@(negedge mclk_i);
				k = k + res_wr_o;
			end
			chk("idle", k, 0);
			wt(2);
			chk("status", k < 900, 1);
			chk("ready", data_ready_output_b_o, 0);
			pen_down_i = 1'b0;
		end
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		#400000;
		mismatches = mismatches + 1;
		print_verdict;
	end
	initial begin
		rst_b_i = 1'b0;
		pen_down_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_addr_i = 5'h00;
		reg_wdata_i = 16'h0000;
		ce_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		rst_b_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("reset", reg_rdata_o, 16'h4000);
		ce_i = 1'b0;
		wr(5'h00, 16'h0400);
		ce_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("frozen", reg_rdata_o, 16'h4000);
		wr(5'h01, 16'h3fff);
		repeat (2) @(negedge mclk_i);
		chk("unmapped", reg_rdata_o, 16'h4000);
		for (i = 0; i < 16; i = i + 1) begin
			wr(5'h00, {1'b0, i > 0 && i < 13, i[3:0], 10'h3ff});
			repeat (4) @(negedge mclk_i);
			chk("fields", reg_rdata_o, {2'b01, i[3:0], 10'h3fe});
			chk("drivers", drv_en_o, i == 13 ? 4'hc : i == 14 ? 4'h3 : i == 15 ? 4'h6 : 4'h0);
		end
		scan({2'b00, 4'h3, 2'b01, 2'b01, 2'b00, 4'h0}, 16'h0000, 1);
		scan({2'b00, 4'h4, 2'b10, 2'b10, 2'b01, 4'h0}, 16'h1000, 1);
		scan({2'b00, 4'h5, 2'b11, 2'b11, 2'b11, 4'h0}, 16'h2300, 2);
		for (i = 6; i < 11; i = i + 1)
			scan({2'b00, i[3:0], 6'h02, 4'h0}, {i[3:0] - 4'h2, 12'h000}, 1);
		scan({2'b00, 4'hc, 6'h03, 4'h0}, 16'h9000, 1);
		scan({2'b00, 4'hb, 6'h02, 4'h0}, 16'h4567, 4);
		scan({2'b00, 4'h1, 6'h02, 4'h0}, 16'h0101, 4);
		scan({2'b00, 4'h2, 6'h12, 4'h0}, 16'h0123, 4);
		scan({2'b10, 4'h3, 6'h02, 4'h2}, 16'h0000, 1);
		scan({2'b10, 4'h1, 6'h02, 4'h4}, 16'h0100, 2);
		wr(5'h00, 16'h0420);
		wt(0);
		wr(5'h00, 16'h3400);
		repeat (3) @(negedge mclk_i);
		chk("redirect", reg_rdata_o, 16'h7400);
		chk("drivers", drv_en_o, 4'hc);
		print_verdict;
	end
endmodule
bind tacs_sequencer tacs_seq_chk i_tacs_seq_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
	.ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .pen_down_i(pen_down_i), .conv_start_o(conv_start_o),
	.conv_pwr_o(conv_pwr_o), .conv_input_o(conv_input_o), .drv_en_o(drv_en_o),
	.res_wr_o(res_wr_o), .res_idx_o(res_idx_o), .data_ready_output_b_o(data_ready_output_b_o));
